// [common/nr_link_if.sv]
`timescale 1ns/1ps
interface nr_link_if;
  import nr_pkg::*;
  // Write-back stream, device to frame store
  logic mem_tvalid;
  logic mem_tready;
  logic [PIX_W-1:0] mem_tdata;
  logic mem_tlast;
  logic mem_tuser;
  // Processed video stream
  logic vid_tvalid;
  logic vid_tready;
  logic [PIX_W-1:0] vid_tdata;
  logic vid_tlast;
  logic vid_tuser;
  // Motion stream
  logic mot_tvalid;
  logic mot_tready;
  logic [PIX_W-1:0] mot_tdata;
  logic mot_tlast;
  logic mot_tuser;
  // Previous frame stream, frame store to device
  logic prev_tvalid;
  logic prev_tready;
  logic [PIX_W-1:0] prev_tdata;
  logic prev_tlast;
  logic prev_tuser;

  modport device (
    output mem_tvalid, mem_tdata, mem_tlast, mem_tuser,
    input mem_tready,
    output vid_tvalid, vid_tdata, vid_tlast, vid_tuser,
    input vid_tready,
    output mot_tvalid, mot_tdata, mot_tlast, mot_tuser,
    input mot_tready,
    input prev_tvalid, prev_tdata, prev_tlast, prev_tuser,
    output prev_tready
  );

  modport partner (
    input mem_tvalid, mem_tdata, mem_tlast, mem_tuser,
    output mem_tready,
    input vid_tvalid, vid_tdata, vid_tlast, vid_tuser,
    output vid_tready,
    input mot_tvalid, mot_tdata, mot_tlast, mot_tuser,
    output mot_tready,
    output prev_tvalid, prev_tdata, prev_tlast, prev_tuser,
    input prev_tready
  );
endinterface

// [common/nr_pkg.sv]
package nr_pkg;
  localparam int PIX_W = 16;
  localparam int CH_W = 8;
  localparam int DIM_W = 11;
  localparam int ADDR_W = 8;
  localparam int MTF_DEPTH = 64;
  localparam int MTF_IDX_W = 6;
  // Fixed resolution used after reset and by the frame store
  localparam logic [DIM_W-1:0] DEF_WIDTH = 11'h020;
  localparam logic [DIM_W-1:0] DEF_HEIGHT = 11'h020;
  localparam int FRAME_PIXELS = 1024;
  localparam int FRAME_PTR_W = 10;
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] WIDTH_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] HEIGHT_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] MTF_SEL_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] MTF_DATA_OFS = 8'h1C;
  // CONTROL fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_BYPASS_BIT = 1;
  localparam int CTRL_SWRST_BIT = 2;
  localparam int CTRL_IRQ_EN_BIT = 3;
  // STATUS / IRQ fields
  localparam int STAT_COMMITTED_BIT = 0;
  localparam int IRQ_FRAME_DONE_BIT = 0;
  localparam int IRQ_W = 1;
  // MTF_SEL fields: index in 5:0, chroma table select in 6
  localparam int MTF_SEL_CHROMA_BIT = 6;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 1'h0;
  // Default curve step: entry i = (63 - i) * 4, entry 63 is zero
  localparam int MTF_DEF_STEP = 4;
endpackage

// [logic/nr_filter_core.sv]
`timescale 1ns/1ps
module nr_filter_core
  import nr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic cur_tvalid_i,
  output logic cur_tready_o,
  input wire logic [PIX_W-1:0] cur_tdata_i,
  input wire logic cur_tuser_i,
  output logic irq_o,
  nr_link_if.device link
);

  function automatic logic [CH_W-1:0] absdiff(input logic [CH_W-1:0] a,
                                              input logic [CH_W-1:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction

  // Current plus scaled (previous - current)
  function automatic logic [CH_W-1:0] blend(input logic [CH_W-1:0] c,
                                            input logic [CH_W-1:0] p,
                                            input logic [CH_W-1:0] k);
    logic signed [8:0] d;
    logic signed [17:0] m;
    logic signed [9:0] s;
    d = $signed({1'b0, p}) - $signed({1'b0, c});
    m = d * $signed({1'b0, k});
    s = $signed(m[17:8]) + $signed({2'b00, c});
    blend = s[7:0];
  endfunction

  logic en_q;
  logic bypass_q;
  logic irq_en_q;
  logic sw_rst_q;
  logic committed_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [DIM_W-1:0] width_q;
  logic [DIM_W-1:0] height_q;
  logic [MTF_IDX_W:0] mtf_sel_q;
  logic [CH_W-1:0] mtf_y_q [MTF_DEPTH];
  logic [CH_W-1:0] mtf_c_q [MTF_DEPTH];
  logic [PIX_W-1:0] cur_q;
  logic cur_sof_q;
  logic [PIX_W-1:0] prev_q;
  logic prev_rdy_q;
  logic armed_q;
  logic [DIM_W-1:0] x_q;
  logic [DIM_W-1:0] y_q;
  logic mem_v_q;
  logic vid_v_q;
  logic mot_v_q;
  logic [PIX_W-1:0] px_q;
  logic [PIX_W-1:0] mot_q;
  logic last_q;
  logic sof_q;
  logic eof_q;

  // Register decode
  wire wr_ctrl = ce_i & reg_wr_i & (reg_addr_i == CONTROL_OFS);
  wire wr_istat = ce_i & reg_wr_i & (reg_addr_i == IRQ_STATUS_OFS);
  wire wr_imask = ce_i & reg_wr_i & (reg_addr_i == IRQ_MASK_OFS);
  wire wr_width = ce_i & reg_wr_i & (reg_addr_i == WIDTH_OFS);
  wire wr_height = ce_i & reg_wr_i & (reg_addr_i == HEIGHT_OFS);
  wire wr_sel = ce_i & reg_wr_i & (reg_addr_i == MTF_SEL_OFS);
  wire wr_mtf = ce_i & reg_wr_i & (reg_addr_i == MTF_DATA_OFS);
  wire [MTF_IDX_W-1:0] sel_idx = mtf_sel_q[MTF_IDX_W-1:0];
  wire sel_chroma = mtf_sel_q[MTF_SEL_CHROMA_BIT];

  // Datapath arithmetic
  wire [CH_W-1:0] cy = cur_q[7:0];
  wire [CH_W-1:0] cc = cur_q[15:8];
  wire [CH_W-1:0] py = prev_q[7:0];
  wire [CH_W-1:0] pc = prev_q[15:8];
  wire [CH_W-1:0] dy = absdiff(cy, py);
  wire [CH_W-1:0] dc = absdiff(cc, pc);
  wire [CH_W-1:0] ky = mtf_y_q[dy[7:2]];
  wire [CH_W-1:0] kc = mtf_c_q[dc[7:2]];
  wire [CH_W-1:0] fy = bypass_q ? cy : blend(cy, py, ky);
  wire [CH_W-1:0] fc = bypass_q ? cc : blend(cc, pc, kc);

  // Raster position, resynced by the source start-of-frame
  wire [DIM_W-1:0] xpos = cur_sof_q ? '0 : x_q;
  wire [DIM_W-1:0] ypos = cur_sof_q ? '0 : y_q;
  wire eol = (xpos == width_q - 11'h001);
  wire eof = eol & (ypos == height_q - 11'h001);

  // Both inputs held and every output slot free
  wire slots_free = (~mem_v_q | link.mem_tready) &
                    (~vid_v_q | link.vid_tready) &
                    (~mot_v_q | link.mot_tready);
  wire fire = ce_i & en_q & armed_q & ~cur_tready_o & ~prev_rdy_q &
              slots_free;
  wire cur_take = ce_i & cur_tready_o & cur_tvalid_i;
  wire prev_take = ce_i & prev_rdy_q & link.prev_tvalid;
  wire frame_done = ce_i & mem_v_q & link.mem_tready & eof_q;
  wire [IRQ_W-1:0] irq_set = {IRQ_W{frame_done}};
  wire [IRQ_W-1:0] irq_clr = wr_istat ? reg_wdata_i[IRQ_W-1:0] : '0;

  // Control registers; the register port runs on the core clock
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      bypass_q <= 1'b0;
      irq_en_q <= 1'b0;
      sw_rst_q <= 1'b0;
      irq_mask_q <= IRQ_MASK_RST;
      width_q <= DEF_WIDTH;
      height_q <= DEF_HEIGHT;
      mtf_sel_q <= '0;
    end else if (ce_i) begin
      sw_rst_q <= wr_ctrl & reg_wdata_i[CTRL_SWRST_BIT];
      if (wr_ctrl) begin
        en_q <= reg_wdata_i[CTRL_ENABLE_BIT];
        bypass_q <= reg_wdata_i[CTRL_BYPASS_BIT];
        irq_en_q <= reg_wdata_i[CTRL_IRQ_EN_BIT];
      end
      if (wr_imask) irq_mask_q <= reg_wdata_i[IRQ_W-1:0];
      if (wr_width) width_q <= reg_wdata_i[DIM_W-1:0];
      if (wr_height) height_q <= reg_wdata_i[DIM_W-1:0];
      if (wr_sel) mtf_sel_q <= reg_wdata_i[MTF_IDX_W:0];
    end
  end

  // Curve tables, default falls to zero at entry 63
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < MTF_DEPTH; i++) begin
        mtf_y_q[i] <= CH_W'((MTF_DEPTH - 1 - i) * MTF_DEF_STEP);
        mtf_c_q[i] <= CH_W'((MTF_DEPTH - 1 - i) * MTF_DEF_STEP);
      end
    end else if (wr_mtf) begin
      if (sel_chroma) mtf_c_q[sel_idx] <= reg_wdata_i[CH_W-1:0];
      else mtf_y_q[sel_idx] <= reg_wdata_i[CH_W-1:0];
    end
  end

  // Status, sticky interrupt bits (set wins) and interrupt output
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      committed_q <= 1'b0;
      irq_stat_q <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (frame_done) committed_q <= 1'b1;
      else if (~en_q | sw_rst_q) committed_q <= 1'b0;
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_o <= irq_en_q & |(irq_stat_q & ~irq_mask_q);
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (ce_i) begin
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          CONTROL_OFS: reg_rdata_o <= {28'h0000000, irq_en_q, 1'b0,
                                       bypass_q, en_q};
          STATUS_OFS: reg_rdata_o <= {31'h00000000, committed_q};
          IRQ_STATUS_OFS: reg_rdata_o <= {{(32-IRQ_W){1'b0}}, irq_stat_q};
          IRQ_MASK_OFS: reg_rdata_o <= {{(32-IRQ_W){1'b0}}, irq_mask_q};
          WIDTH_OFS: reg_rdata_o <= {{(32-DIM_W){1'b0}}, width_q};
          HEIGHT_OFS: reg_rdata_o <= {{(32-DIM_W){1'b0}}, height_q};
          MTF_SEL_OFS: reg_rdata_o <= {25'h0000000, mtf_sel_q};
          MTF_DATA_OFS: reg_rdata_o <= {24'h000000, sel_chroma ?
                                        mtf_c_q[sel_idx] : mtf_y_q[sel_idx]};
          default: reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // Input holding stages; both streams pair pixel for pixel, except that prev drains alone while bypass_q is set and en_q clear
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cur_tready_o <= 1'b0;
      prev_rdy_q <= 1'b0;
      armed_q <= 1'b0;
      cur_q <= '0;
      cur_sof_q <= 1'b0;
      prev_q <= '0;
    end else if (ce_i) begin
      armed_q <= 1'b1;
      // Readies open on the first enabled edge after reset
      if (sw_rst_q | ~armed_q) begin
        cur_tready_o <= 1'b1;
        prev_rdy_q <= 1'b1;
      end else begin
        if (cur_take) begin
          cur_q <= cur_tdata_i;
          cur_sof_q <= cur_tuser_i;
          cur_tready_o <= 1'b0;
        end else if (fire) begin
          cur_tready_o <= 1'b1;
        end
        if (prev_take) begin
          prev_q <= link.prev_tdata;
          prev_rdy_q <= 1'b0;
        end else if (fire | ~prev_rdy_q & bypass_q & ~en_q) begin
          prev_rdy_q <= 1'b1;
        end
      end
    end
  end

  // Output stage feeding the three streams
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_v_q <= 1'b0;
      vid_v_q <= 1'b0;
      mot_v_q <= 1'b0;
      px_q <= '0;
      mot_q <= '0;
      last_q <= 1'b0;
      sof_q <= 1'b0;
      eof_q <= 1'b0;
      x_q <= '0;
      y_q <= '0;
    end else if (ce_i) begin
      if (sw_rst_q) begin
        mem_v_q <= 1'b0;
        vid_v_q <= 1'b0;
        mot_v_q <= 1'b0;
        x_q <= '0;
        y_q <= '0;
      end else if (fire) begin
        mem_v_q <= 1'b1;
        vid_v_q <= 1'b1;
        mot_v_q <= 1'b1;
        px_q <= {fc, fy};
        mot_q <= {dc, dy};
        last_q <= eol;
        sof_q <= (xpos == '0) & (ypos == '0);
        eof_q <= eof;
        x_q <= eol ? '0 : xpos + 11'h001;
        y_q <= eof ? '0 : (eol ? ypos + 11'h001 : ypos);
      end else begin
        if (link.mem_tready) mem_v_q <= 1'b0;
        if (link.vid_tready) vid_v_q <= 1'b0;
        if (link.mot_tready) mot_v_q <= 1'b0;
      end
    end
  end

  // Stream ports
  assign link.mem_tvalid = mem_v_q;
  assign link.mem_tdata = px_q;
  assign link.mem_tlast = last_q;
  assign link.mem_tuser = sof_q;
  assign link.vid_tvalid = vid_v_q;
  assign link.vid_tdata = px_q;
  assign link.vid_tlast = last_q;
  assign link.vid_tuser = sof_q;
  assign link.mot_tvalid = mot_v_q;
  assign link.mot_tdata = mot_q;
  assign link.mot_tlast = last_q;
  assign link.mot_tuser = sof_q;
  assign link.prev_tready = prev_rdy_q;

endmodule // nr_filter_core

// [logic/nr_frame_store.sv]
`timescale 1ns/1ps
module nr_frame_store
  import nr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  output logic vid_tvalid_o,
  input wire logic vid_tready_i,
  output logic [PIX_W-1:0] vid_tdata_o,
  output logic vid_tlast_o,
  output logic vid_tuser_o,
  output logic mot_tvalid_o,
  input wire logic mot_tready_i,
  output logic [PIX_W-1:0] mot_tdata_o,
  output logic mot_tlast_o,
  output logic mot_tuser_o,
  output logic frame_stored_o,
  nr_link_if.partner link
);

  logic [PIX_W-1:0] frame_q [FRAME_PIXELS];
  logic mem_rdy_q;
  logic [FRAME_PTR_W-1:0] wptr_q;
  logic [FRAME_PTR_W-1:0] rptr_q;
  logic [DIM_W-1:0] rcol_q;
  logic prev_v_q;
  logic [PIX_W-1:0] prev_q;
  logic prev_last_q;
  logic prev_sof_q;
  logic [1:0] snk_rdy_q;

  wire mem_take = ce_i & mem_rdy_q & link.mem_tvalid;
  wire [FRAME_PTR_W-1:0] wsel = link.mem_tuser ? '0 : wptr_q;
  wire prev_load = ce_i & (~prev_v_q | link.prev_tready);
  wire rlast = (rcol_q == DEF_WIDTH - 11'h001);
  wire rwrap = (rptr_q == FRAME_PTR_W'(FRAME_PIXELS - 1));
  // Pixel already written back in this first round of the frame
  wire rd_filled = frame_stored_o | (rptr_q < wptr_q);
  wire [1:0] snk_take = {ce_i & snk_rdy_q[1] & link.mot_tvalid,
                         ce_i & snk_rdy_q[0] & link.vid_tvalid};
  wire [1:0] usr_ready = {mot_tready_i, vid_tready_i};

  // Frame memory, written from the write-back stream
  always_ff @(posedge clk_sys_i) begin
    if (mem_take) frame_q[wsel] <= link.mem_tdata;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_rdy_q <= 1'b0;
      wptr_q <= '0;
      frame_stored_o <= 1'b0;
    end else if (ce_i) begin
      mem_rdy_q <= 1'b1;
      if (mem_take) begin
        wptr_q <= wsel + 10'h001;
        if (wsel == FRAME_PTR_W'(FRAME_PIXELS - 1)) frame_stored_o <= 1'b1;
      end
    end
  end

  // Replays the stored frame as the previous frame, zero until filled
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prev_v_q <= 1'b0;
      prev_q <= '0;
      prev_last_q <= 1'b0;
      prev_sof_q <= 1'b0;
      rptr_q <= '0;
      rcol_q <= '0;
    end else if (prev_load) begin
      prev_v_q <= 1'b1;
      prev_q <= rd_filled ? frame_q[rptr_q] : '0;
      prev_last_q <= rlast;
      prev_sof_q <= (rptr_q == '0);
      rptr_q <= rwrap ? '0 : rptr_q + 10'h001;
      rcol_q <= rlast ? '0 : rcol_q + 11'h001;
    end
  end

  // One-entry holding sinks for the video and motion streams
  logic [PIX_W+1:0] snk_in [2];
  logic [PIX_W+1:0] snk_q [2];
  logic [1:0] snk_v_q;
  assign snk_in[0] = {link.vid_tuser, link.vid_tlast, link.vid_tdata};
  assign snk_in[1] = {link.mot_tuser, link.mot_tlast, link.mot_tdata};

  for (genvar i = 0; i < 2; i++) begin : g_sink
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        snk_rdy_q[i] <= 1'b0;
        snk_v_q[i] <= 1'b0;
        snk_q[i] <= '0;
      end else if (ce_i) begin
        if (snk_take[i]) begin
          snk_q[i] <= snk_in[i];
          snk_v_q[i] <= 1'b1;
          snk_rdy_q[i] <= 1'b0;
        end else if (snk_v_q[i] & usr_ready[i]) begin
          snk_v_q[i] <= 1'b0;
          snk_rdy_q[i] <= 1'b1;
        end else if (~snk_v_q[i]) begin
          snk_rdy_q[i] <= 1'b1;
        end
      end
    end
  end

  assign link.mem_tready = mem_rdy_q;
  assign link.prev_tvalid = prev_v_q;
  assign link.prev_tdata = prev_q;
  assign link.prev_tlast = prev_last_q;
  assign link.prev_tuser = prev_sof_q;
  assign link.vid_tready = snk_rdy_q[0];
  assign link.mot_tready = snk_rdy_q[1];
  assign vid_tvalid_o = snk_v_q[0];
  assign {vid_tuser_o, vid_tlast_o, vid_tdata_o} = snk_q[0];
  assign mot_tvalid_o = snk_v_q[1];
  assign {mot_tuser_o, mot_tlast_o, mot_tdata_o} = snk_q[1];

endmodule // nr_frame_store

// [testbench/nr_link_properties.sv]
`timescale 1ns/1ps
module nr_link_properties
  import nr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mem_tvalid,
  input wire logic mem_tready,
  input wire logic [PIX_W-1:0] mem_tdata,
  input wire logic mem_tlast,
  input wire logic mem_tuser,
  input wire logic vid_tvalid,
  input wire logic vid_tready,
  input wire logic [PIX_W-1:0] vid_tdata,
  input wire logic vid_tlast,
  input wire logic vid_tuser,
  input wire logic mot_tvalid,
  input wire logic mot_tready,
  input wire logic [PIX_W-1:0] mot_tdata,
  input wire logic mot_tlast,
  input wire logic mot_tuser,
  input wire logic prev_tvalid,
  input wire logic prev_tready,
  input wire logic [PIX_W-1:0] prev_tdata
);
  // Position of the next write-back beat within its frame
  logic [FRAME_PTR_W-1:0] beat_q;
  logic [FRAME_PTR_W-1:0] beat_d;
  wire mem_beat = mem_tvalid && mem_tready;
  assign beat_d = mem_tuser ? 10'h001 : beat_q + 10'h001;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) beat_q <= '0;
    else if (mem_beat) beat_q <= beat_d;
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  property p_mem_hold;
    mem_tvalid && !mem_tready |=>
      mem_tvalid && $stable({mem_tdata, mem_tlast, mem_tuser});
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("write-back beat changed while stalled");
  property p_vid_hold;
    vid_tvalid && !vid_tready |=>
      vid_tvalid && $stable({vid_tdata, vid_tlast, vid_tuser});
  endproperty
  a_vid_hold: assert property (p_vid_hold)
    else $error("video beat changed while stalled");
  property p_mot_hold;
    mot_tvalid && !mot_tready |=>
      mot_tvalid && $stable({mot_tdata, mot_tlast, mot_tuser});
  endproperty
  a_mot_hold: assert property (p_mot_hold)
    else $error("motion beat changed while stalled");
  property p_prev_hold;
    prev_tvalid && !prev_tready |=> prev_tvalid && $stable(prev_tdata);
  endproperty
  a_prev_hold: assert property (p_prev_hold)
    else $error("previous-frame beat changed while stalled");
  property p_same_pix;
    $rose(mem_tvalid) |-> vid_tvalid && mot_tvalid && vid_tdata == mem_tdata
      && {vid_tuser, vid_tlast, mot_tuser} == {mem_tuser, mem_tlast, mem_tuser};
  endproperty
  a_same_pix: assert property (p_same_pix)
    else $error("video and write-back streams disagree");
  property p_rst_release;
    $fell(rst_i) |-> !mem_tvalid && !prev_tready ##1 mem_tready && prev_tready;
  endproperty
  a_rst_release: assert property (p_rst_release)
    else $error("readies wrong after reset release");
  property p_frame_len;
    mem_beat |-> mem_tuser == (beat_q == '0);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame start not every frame of beats");
  property p_line_end;
    mem_beat |-> mem_tlast == ((beat_q % DEF_WIDTH) == DEF_WIDTH - 1);
  endproperty
  a_line_end: assert property (p_line_end)
    else $error("line end marker misplaced");

  c_sof: cover property (mem_beat && mem_tuser);
  c_eof: cover property (mem_beat && beat_q == 10'h3FF);
  c_stall: cover property (vid_tvalid && !vid_tready);
endmodule // nr_link_properties

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import nr_pkg::*;
;
  logic clk_sys_i, rst_i, ce_i, reg_wr, reg_rd, irq, frame_stored;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic cur_tvalid, cur_tready, cur_tuser;
  logic vid_tvalid, vid_tready, vid_tlast, vid_tuser;
  logic mot_tvalid, mot_tready, mot_tlast, mot_tuser;
  logic [PIX_W-1:0] cur_tdata, vid_tdata, mot_tdata;
  logic [PIX_W-1:0] store [FRAME_PIXELS];
  logic [PIX_W-1:0] exp_v[$], exp_m[$];
  logic [ADDR_W-1:0] ra [7] = '{CONTROL_OFS, STATUS_OFS, IRQ_STATUS_OFS,
    IRQ_MASK_OFS, WIDTH_OFS, HEIGHT_OFS, 8'h40};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'(IRQ_MASK_RST),
    32'(DEF_WIDTH), 32'(DEF_HEIGHT), 32'h0};
  logic [7:0] mi [4] = '{8'h00, 8'h05, 8'h3F, 8'h7F};
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int vx = 0;
  int mx = 0;

  nr_link_if link ();
  nr_filter_core nr_filter_core_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .cur_tvalid_i(cur_tvalid), .cur_tready_o(cur_tready),
    .cur_tdata_i(cur_tdata), .cur_tuser_i(cur_tuser), .irq_o(irq),
    .link(link)
  );
  nr_frame_store nr_frame_store_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .vid_tvalid_o(vid_tvalid), .vid_tready_i(vid_tready),
    .vid_tdata_o(vid_tdata), .vid_tlast_o(vid_tlast), .vid_tuser_o(vid_tuser),
    .mot_tvalid_o(mot_tvalid), .mot_tready_i(mot_tready),
    .mot_tdata_o(mot_tdata), .mot_tlast_o(mot_tlast), .mot_tuser_o(mot_tuser),
    .frame_stored_o(frame_stored), .link(link)
  );
  nr_link_properties nr_link_properties_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .mem_tvalid(link.mem_tvalid), .mem_tready(link.mem_tready),
    .mem_tdata(link.mem_tdata), .mem_tlast(link.mem_tlast),
    .mem_tuser(link.mem_tuser), .vid_tvalid(link.vid_tvalid),
    .vid_tready(link.vid_tready), .vid_tdata(link.vid_tdata),
    .vid_tlast(link.vid_tlast), .vid_tuser(link.vid_tuser),
    .mot_tvalid(link.mot_tvalid), .mot_tready(link.mot_tready),
    .mot_tdata(link.mot_tdata), .mot_tlast(link.mot_tlast),
    .mot_tuser(link.mot_tuser), .prev_tvalid(link.prev_tvalid),
    .prev_tready(link.prev_tready), .prev_tdata(link.prev_tdata)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Test pattern per frame; values stay clear of 8-bit overflow
  function automatic logic [15:0] pix(input int i, input int f);
    logic [15:0] b;
    b = {4'h8, 4'(i), 2'b01, 6'(i)};
    return f == 1 ? b ^ 16'h0101 : (f == 2 ? b ^ 16'h1010 : b);
  endfunction

  // One channel: filtered value, or motion magnitude when m is set
  function automatic logic [7:0] ch(input logic [7:0] c, input logic [7:0] p,
                                    input bit m);
    int d, a, k;
    d = int'(p) - int'(c);
    a = d < 0 ? -d : d;
    k = (63 - (a >> 2)) * MTF_DEF_STEP;
    return m ? 8'(a) : 8'(int'(c) + ((d * k) >>> 8));
  endfunction

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd <= 1'b0;
    @(negedge clk_sys_i);
    check($sformatf("reg_%h", a), reg_rdata, e);
  endtask

  task automatic irq_after(input logic e);
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("irq", irq, e);
  endtask

  task automatic send_frame(input int f, input bit byp);
    logic [15:0] c, p;
    int t;
    for (int i = 0; i < FRAME_PIXELS; i++) begin
      c = pix(i, f);
      p = store[i];
      store[i] = byp ? c : {ch(c[15:8], p[15:8], 0), ch(c[7:0], p[7:0], 0)};
      exp_v.push_back(store[i]);
      exp_m.push_back({ch(c[15:8], p[15:8], 1), ch(c[7:0], p[7:0], 1)});
      cur_tvalid <= 1'b1;
      cur_tdata <= c;
      cur_tuser <= (i == 0);
      t = 0;
      do begin
        @(posedge clk_sys_i);
        t++;
      end while (cur_tready !== 1'b1 && t < 64);
      check("cur_ready", cur_tready, 1'b1);
    end
    cur_tvalid <= 1'b0;
    t = 0;
    while (exp_v.size() + exp_m.size() > 0 && t < 9000) begin
      @(posedge clk_sys_i);
      t++;
    end
    check("drained", exp_v.size() + exp_m.size(), 0);
    repeat (8) @(posedge clk_sys_i);
  endtask

  // Cycle count, timeout and stalling readies on the user side
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    vid_tready <= (cyc % 8) != 5;
    mot_tready <= (cyc % 4) != 2;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end

  always @(posedge clk_sys_i) begin
    if (vid_tvalid && vid_tready) begin
      check("vid_data", vid_tdata, exp_v.size() ? exp_v.pop_front() : '1);
      check("vid_sof", vid_tuser, vx == 0);
      check("vid_eol", vid_tlast, vx % DEF_WIDTH == DEF_WIDTH - 1);
      vx = (vx + 1) % FRAME_PIXELS;
    end
    if (mot_tvalid && mot_tready) begin
      check("mot_data", mot_tdata, exp_m.size() ? exp_m.pop_front() : '1);
      check("mot_sof", mot_tuser, mx == 0);
      check("mot_eol", mot_tlast, mx % DEF_WIDTH == DEF_WIDTH - 1);
      mx = (mx + 1) % FRAME_PIXELS;
    end
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cur_tvalid = 1'b0;
    cur_tdata = '0;
    cur_tuser = 1'b0;
    vid_tready = 1'b1;
    mot_tready = 1'b1;
    foreach (store[i]) store[i] = '0;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    reg_write(8'h40, 32'hFFFF_FFFF);
    foreach (ra[i]) reg_check(ra[i], rv[i]);
    reg_write(WIDTH_OFS, 32'(DEF_WIDTH));
    reg_write(HEIGHT_OFS, 32'(DEF_HEIGHT));
    foreach (mi[j]) begin
      reg_write(MTF_SEL_OFS, 32'(mi[j]));
      reg_check(MTF_DATA_OFS, 32'((63 - int'(mi[j][5:0])) * MTF_DEF_STEP));
    end
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    reg_write(IRQ_MASK_OFS, 32'h1);
    ce_i <= 1'b1;
    reg_check(IRQ_MASK_OFS, 32'h0);
    reg_write(CONTROL_OFS, 32'h0000_000B);
    send_frame(0, 1'b1);
    reg_check(STATUS_OFS, 32'h1);
    reg_check(IRQ_STATUS_OFS, 32'h1);
    check("irq", irq, 1'b1);
    check("stored", frame_stored, 1'b1);
    reg_write(IRQ_MASK_OFS, 32'h1);
    irq_after(1'b0);
    reg_write(IRQ_MASK_OFS, 32'h0);
    irq_after(1'b1);
    reg_write(CONTROL_OFS, 32'h3);
    irq_after(1'b0);
    reg_write(CONTROL_OFS, 32'hB);
    reg_write(IRQ_STATUS_OFS, 32'h1);
    irq_after(1'b0);
    reg_check(IRQ_STATUS_OFS, 32'h0);
    send_frame(1, 1'b1);
    reg_write(CONTROL_OFS, 32'h9);
    reg_write(IRQ_STATUS_OFS, 32'h1);
    send_frame(2, 1'b0);
    reg_check(IRQ_STATUS_OFS, 32'h1);
    reg_write(CONTROL_OFS, 32'hD);
    reg_check(CONTROL_OFS, 32'h9);
    reg_check(STATUS_OFS, 32'h0);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    reg_check(IRQ_STATUS_OFS, 32'h0);
    check("irq", irq, 1'b0);
    tally_and_finish();
  end
endmodule // tb_top
